// [include/wwd_count_if.sv]
interface wwd_count_if;
    logic run;
    logic reload;
    logic [23:0] reload_value;
    logic [23:0] count;
    logic timeout;
    modport ctrl (output run, output reload, output reload_value, input count, input timeout);
    modport core (input run, input reload, input reload_value, output count, output timeout);
endinterface

// [include/wwd_pkg.sv]
// Summary of operation
// RULE_01: Run enable bit 0 is sticky; one runs the counter, zero stops it.
// RULE_02: Reset on timeout bit 1 is sticky until a reset.
// RULE_03: Timeout resets the chip only when reset on timeout bit is one.
// RULE_04: Timeout flag sets on timeout, feed error or guard violation; survives watchdog reset.
// RULE_05: Reset on timeout bit one plus timeout flag requests a chip reset.
// RULE_06: Warning flag bit 3 sets at the warning compare value; software clears.
// RULE_07: Reload guard bit 4 sets once, ignores zero writes, clears on reset.
// RULE_08: Guard zero lets reload value writes through at any time.
// RULE_09: Guard one accepts reload writes only below warning and window compares.
// RULE_10: Clock lock bit 5 keeps the selected clock source powered.
// RULE_11: Clock lock refuses switching to a disabled or powered down source.
// RULE_12: Clock lock sets once, ignores zero writes, any reset clears it.
// RULE_13: Setup register writes act only after a following valid feed; clock lock bit 5 and the flag clears act at once.
// RULE_14: Writing 0xAA then 0x55 to the feed register reloads the counter.
// RULE_15: Reload value is 24-bit read/write, resets to 0xFF.
// RULE_16: Counter readback is read-only 24-bit current count, resets to 0xFF.
// RULE_17: Window compare is read/write and resets to 0xFFFFFF.
// RULE_18: Warning compare is read/write and resets to zero.
// RULE_19: Software writes no ones to setup bits 31:6.
// RULE_20: Setup resets to zero at 0x000; reload at 0x004; feed at 0x008.
// RULE_21: Reload writes below 0xFF store 0xFF.
// RULE_22: After 0xAA, any other access than writing 0x55 sets the timeout flag.
// RULE_23: In reset mode a feed above the window compare is a watchdog event.
// RULE_24: Counting and feed error checks start only after a valid feed.
// RULE_25: Feed register reads return zero and only count as an access.
package wwd_pkg;
    localparam int ADDR_W = 12;
    localparam int CNT_W = 24;
    localparam logic [ADDR_W-1:0] OFS_SETUP = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_RELOAD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_FEED = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_SOURCE = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_WARN = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_WINDOW = 12'h018;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_RESET = 1;
    localparam int BIT_TIMEOUT = 2;
    localparam int BIT_WARNING = 3;
    localparam int BIT_GUARD = 4;
    localparam int BIT_LOCK = 5;
    localparam int BIT_SRC_SEL = 0;
    localparam int BIT_SRC_LOCK = 31;
    localparam int SOURCES = 2;
    localparam logic [CNT_W-1:0] RELOAD_RESET = 24'h0000ff;
    localparam logic [CNT_W-1:0] RELOAD_MIN = 24'h0000ff;
    localparam logic [CNT_W-1:0] COUNT_RESET = 24'h0000ff;
    localparam logic [CNT_W-1:0] WINDOW_RESET = 24'hffffff;
    localparam logic [CNT_W-1:0] WARN_RESET = 24'h000000;
    localparam logic [7:0] FEED_KEY_FIRST = 8'haa;
    localparam logic [7:0] FEED_KEY_SECOND = 8'h55;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    typedef enum logic [1:0] {
        FEED_IDLE = 2'b01,
        FEED_ARMED = 2'b10
    } wwd_feed_type;
endpackage

// [rtl/wwd_counter.sv]
module wwd_counter
    import wwd_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic sys_reset,
    input wire logic tick_enable,
    wwd_count_if.core cnt
);
    logic [1:0] prescale;
    logic quarter_tick;

    // The tick is divided by four before it reaches the counter.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prescale <= 2'h0;
        end else if (sys_reset || cnt.reload || !cnt.run) begin
            prescale <= 2'h0;
        end else if (tick_enable) begin
            prescale <= prescale + 2'h1;
        end
    end

    assign quarter_tick = cnt.run && tick_enable && (prescale == PRESCALE_LAST);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt.count <= COUNT_RESET;
        end else if (sys_reset) begin
            cnt.count <= COUNT_RESET;
        end else if (cnt.reload) begin
            cnt.count <= cnt.reload_value; // RULE_14
        end else if (quarter_tick && (cnt.count != 24'h000000)) begin
            cnt.count <= cnt.count - 24'h000001;
        end
    end

    assign cnt.timeout = quarter_tick && (cnt.count == 24'h000001);
endmodule

// [rtl/wwd_regs.sv]
module wwd_regs
    import wwd_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic sys_reset,
    input wire logic tick_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] source_ready,
    output logic chip_reset_req,
    output logic warning_irq,
    output logic source_select,
    output logic [1:0] source_hold
);
    // The counter and its prescaler sit in their own module.
    wwd_count_if cnt ();

    wwd_counter u_counter (
        .clock(clock),
        .rstn(rstn),
        .sys_reset(sys_reset),
        .tick_enable(tick_enable),
        .cnt(cnt)
    );

    logic setup_enable;
    logic setup_reset;
    logic setup_guard;
    logic setup_lock;
    logic act_enable;
    logic act_reset;
    logic act_guard;
    logic started;
    logic timeout_flag;
    logic warning_flag;
    logic [23:0] reload_value;
    logic [23:0] warn_cmp;
    logic [23:0] window_cmp;
    logic source_sel_lock;
    wwd_feed_type feed_state;
    wwd_feed_type next_feed_state;

    logic access;
    logic wr;
    logic setup_phase_rd;
    logic hit_setup;
    logic hit_reload;
    logic hit_feed;
    logic hit_count;
    logic hit_source;
    logic hit_warn;
    logic hit_window;
    logic mapped;
    logic running;
    logic key_first;
    logic valid_feed;
    logic feed_error;
    logic window_open;
    logic guard_violation;
    logic early_feed;
    logic flag_set;
    logic target_ready;
    logic [31:0] next_prdata;

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign setup_phase_rd = psel && !penable && !pwrite;
    // No wait states are inserted.
    assign pready = 1'b1;

    // Address decoding selects at most one register.
    always_comb begin
        hit_setup = 1'b0;
        hit_reload = 1'b0;
        hit_feed = 1'b0;
        hit_count = 1'b0;
        hit_source = 1'b0;
        hit_warn = 1'b0;
        hit_window = 1'b0;
        if (paddr == OFS_SETUP) begin
            hit_setup = 1'b1; // RULE_20
        end else if (paddr == OFS_RELOAD) begin
            hit_reload = 1'b1;
        end else if (paddr == OFS_FEED) begin
            hit_feed = 1'b1;
        end else if (paddr == OFS_COUNT) begin
            hit_count = 1'b1;
        end else if (paddr == OFS_SOURCE) begin
            hit_source = 1'b1;
        end else if (paddr == OFS_WARN) begin
            hit_warn = 1'b1;
        end else if (paddr == OFS_WINDOW) begin
            hit_window = 1'b1;
        end
    end

    // Unmapped offsets answer with an error response.
    assign mapped = hit_setup || hit_reload || hit_feed || hit_count
        || hit_source || hit_warn || hit_window;
    assign pslverr = access && !mapped;

    // The counter runs only once a valid feed has followed enable.
    assign running = act_enable && started; // RULE_24

    assign key_first = wr && hit_feed && (pwdata[7:0] == FEED_KEY_FIRST);
    assign valid_feed = wr && hit_feed && (feed_state == FEED_ARMED)
        && (pwdata[7:0] == FEED_KEY_SECOND); // RULE_14

    // Any other access while armed breaks the sequence.
    assign feed_error = (feed_state == FEED_ARMED) && access && !valid_feed
        && running; // RULE_22

    assign window_open = (cnt.count < warn_cmp) && (cnt.count < window_cmp); // RULE_09
    assign guard_violation = wr && hit_reload && act_guard && !window_open; // RULE_09
    assign early_feed = valid_feed && running && act_reset
        && (cnt.count > window_cmp); // RULE_23

    assign flag_set = cnt.timeout || feed_error || guard_violation || early_feed; // RULE_04

    // The first key arms the sequence and the next access closes it.
    always_comb begin
        next_feed_state = feed_state;
        case (feed_state)
            FEED_IDLE: begin
                if (key_first) begin
                    next_feed_state = FEED_ARMED;
                end
            end
            FEED_ARMED: begin
                if (access) begin
                    next_feed_state = FEED_IDLE;
                end
            end
            default: begin
                next_feed_state = FEED_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            feed_state <= FEED_IDLE;
        end else if (sys_reset) begin
            feed_state <= FEED_IDLE;
        end else begin
            feed_state <= next_feed_state;
        end
    end

    // Written setup bits are sticky once set.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            setup_enable <= 1'b0;
            setup_reset <= 1'b0;
            setup_guard <= 1'b0;
            setup_lock <= 1'b0;
        end else if (sys_reset) begin
            setup_enable <= 1'b0;
            setup_reset <= 1'b0;
            setup_guard <= 1'b0;
            setup_lock <= 1'b0; // RULE_12
        end else if (wr && hit_setup) begin
            setup_enable <= setup_enable || pwdata[BIT_ENABLE]; // RULE_01
            setup_reset <= setup_reset || pwdata[BIT_RESET]; // RULE_02
            setup_guard <= setup_guard || pwdata[BIT_GUARD]; // RULE_07
            setup_lock <= setup_lock || pwdata[BIT_LOCK]; // RULE_12
        end
    end

    // The operating copies follow the written bits only on a valid feed.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            act_enable <= 1'b0;
            act_reset <= 1'b0;
            act_guard <= 1'b0;
        end else if (sys_reset) begin
            act_enable <= 1'b0;
            act_reset <= 1'b0;
            act_guard <= 1'b0;
        end else if (valid_feed) begin
            act_enable <= setup_enable; // RULE_13
            act_reset <= setup_reset; // RULE_13
            act_guard <= setup_guard; // RULE_13
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            started <= 1'b0;
        end else if (sys_reset) begin
            started <= 1'b0;
        end else if (valid_feed && setup_enable) begin
            started <= 1'b1; // RULE_24
        end
    end

    // The timeout flag is cleared only by the external reset or software.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timeout_flag <= 1'b0;
        end else if (flag_set) begin
            timeout_flag <= 1'b1; // RULE_04
        end else if (wr && hit_setup && !pwdata[BIT_TIMEOUT]) begin
            timeout_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            warning_flag <= 1'b0;
        end else if (sys_reset) begin
            warning_flag <= 1'b0;
        end else if (running && (cnt.count == warn_cmp)) begin
            warning_flag <= 1'b1; // RULE_06
        end else if (wr && hit_setup && !pwdata[BIT_WARNING]) begin
            warning_flag <= 1'b0;
        end
    end

    assign warning_irq = warning_flag;

    // A set timeout flag in reset mode raises the chip reset one cycle later.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chip_reset_req <= 1'b0;
        end else if (sys_reset) begin
            chip_reset_req <= 1'b0;
        end else begin
            chip_reset_req <= act_reset && timeout_flag; // RULE_03 RULE_05
        end
    end

    // Reload writes are clamped to the minimum and may be refused by the guard.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reload_value <= RELOAD_RESET; // RULE_15
        end else if (sys_reset) begin
            reload_value <= RELOAD_RESET;
        end else if (wr && hit_reload && (!act_guard || window_open)) begin // RULE_08
            if (pwdata[23:0] < RELOAD_MIN) begin
                reload_value <= RELOAD_MIN; // RULE_21
            end else begin
                reload_value <= pwdata[23:0];
            end
        end
    end

    // Compare values for the warning flag and the feed window.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            warn_cmp <= WARN_RESET; // RULE_18
        end else if (sys_reset) begin
            warn_cmp <= WARN_RESET;
        end else if (wr && hit_warn) begin
            warn_cmp <= pwdata[23:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            window_cmp <= WINDOW_RESET; // RULE_17
        end else if (sys_reset) begin
            window_cmp <= WINDOW_RESET;
        end else if (wr && hit_window) begin
            window_cmp <= pwdata[23:0];
        end
    end

    // A locked source may only move to a source that is running.
    assign target_ready = pwdata[BIT_SRC_SEL] ? source_ready[1] : source_ready[0];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            source_select <= 1'b0;
        end else if (sys_reset) begin
            source_select <= 1'b0;
        end else if (wr && hit_source && !source_sel_lock
            && (!setup_lock || target_ready)) begin // RULE_11
            source_select <= pwdata[BIT_SRC_SEL];
        end
    end

    // Bit 31 of the source register freezes the select bit until a reset.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            source_sel_lock <= 1'b0;
        end else if (sys_reset) begin
            source_sel_lock <= 1'b0;
        end else if (wr && hit_source && pwdata[BIT_SRC_LOCK]) begin
            source_sel_lock <= 1'b1;
        end
    end

    // The locked source is held powered and enabled.
    genvar s;
    generate
        for (s = 0; s < SOURCES; s = s + 1) begin : g_hold
            assign source_hold[s] = setup_lock && (source_select == (s == 1)); // RULE_10
        end
    endgenerate

    // Controls handed to the counter.
    assign cnt.run = running;
    assign cnt.reload = valid_feed; // RULE_14
    assign cnt.reload_value = reload_value;

    // Read multiplexer; unused bits read zero.
    always_comb begin
        next_prdata = 32'h00000000;
        if (hit_setup) begin
            next_prdata[BIT_ENABLE] = setup_enable;
            next_prdata[BIT_RESET] = setup_reset;
            next_prdata[BIT_TIMEOUT] = timeout_flag;
            next_prdata[BIT_WARNING] = warning_flag;
            next_prdata[BIT_GUARD] = setup_guard;
            next_prdata[BIT_LOCK] = setup_lock;
        end else if (hit_reload) begin
            next_prdata[23:0] = reload_value;
        end else if (hit_feed) begin
            next_prdata = 32'h00000000; // RULE_25
        end else if (hit_count) begin
            next_prdata[23:0] = cnt.count; // RULE_16
        end else if (hit_source) begin
            next_prdata[BIT_SRC_SEL] = source_select;
            next_prdata[BIT_SRC_LOCK] = source_sel_lock;
        end else if (hit_warn) begin
            next_prdata[23:0] = warn_cmp;
        end else if (hit_window) begin
            next_prdata[23:0] = window_cmp;
        end
    end

    // Read data are captured in the setup phase and stand through the access phase.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase_rd) begin
            prdata <= next_prdata;
        end
    end
endmodule

// [tb/tb.sv]
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wwd_pkg::*;
    logic clock = 0;
    logic rstn = 0;
    logic sys_reset = 0;
    logic [1:0] source_ready = 2'h3;
    logic tick_enable, psel, penable, pwrite, pready, pslverr;
    logic chip_reset_req, warning_irq, source_select;
    logic [1:0] source_hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    int miscompares = 0;
    int checked = 0;
    always #12.5 clock = ~clock;
    wwd_regs wwd_regs_inst (.clock(clock), .rstn(rstn), .sys_reset(sys_reset),
        .tick_enable(tick_enable), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .source_ready(source_ready), .chip_reset_req(chip_reset_req),
        .warning_irq(warning_irq), .source_select(source_select), .source_hold(source_hold));
    wwd_cpu_model wwd_cpu_model_inst (.clock(clock), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .tick_enable(tick_enable));
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wwd_cpu_model_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a);
        wwd_cpu_model_inst.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic pulse_sys;
        @(posedge clock);
        #1 sys_reset = 1;
        @(posedge clock);
        #1 sys_reset = 0;
    endtask
    task automatic feed;
        wr(OFS_FEED, 32'haa);
        wr(OFS_FEED, 32'h55);
    endtask
    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic t_reset_values;
        logic [11:0] ra [7] = '{OFS_SETUP, OFS_RELOAD, OFS_COUNT, OFS_SOURCE, OFS_WARN,
                                OFS_WINDOW, OFS_FEED};
        logic [31:0] rv [7] = '{32'h0, 32'hff, 32'hff, 32'h0, 32'h0, 32'hffffff, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            `CHK(q, rv[i])
        end
        wr(OFS_COUNT, 32'h5);
        rd(OFS_COUNT);
        `CHK(q, 32'hff)
        rd(12'h01c);
        `CHK(e, 1'b1)
    endtask
    task automatic t_reload;
        wr(OFS_RELOAD, 32'h10);
        rd(OFS_RELOAD);
        `CHK(q, 32'hff)
        wr(OFS_RELOAD, 32'h123456);
        rd(OFS_RELOAD);
        `CHK(q, 32'h123456)
    endtask
    task automatic t_lock;
        wr(OFS_SETUP, 32'h33);
        wr(OFS_SETUP, 32'h0);
        rd(OFS_SETUP);
        `CHK(q, 32'h33)
        `CHK(source_hold, 2'h1)
        source_ready = 2'h1;
        wr(OFS_SOURCE, 32'h1);
        `CHK(source_select, 1'b0)
        source_ready = 2'h3;
        wr(OFS_SOURCE, 32'h1);
        `CHK(source_hold, 2'h2)
        pulse_sys();
        rd(OFS_SETUP);
        `CHK(q, 32'h0)
    endtask
    task automatic t_run;
        int n;
        wr(OFS_RELOAD, 32'h100);
        wr(OFS_WARN, 32'hfe);
        wr(OFS_SETUP, 32'h1);
        repeat (40) @(posedge clock);
        rd(OFS_COUNT);
        `CHK(q, 32'hff)
        feed();
        rd(OFS_COUNT);
        `CHK(q, 32'h100)
        for (n = 0; n < 100 && warning_irq !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        `CHK(warning_irq, 1'b1)
        for (n = 0; n < 1000 && q[2] !== 1'b1; n++) rd(OFS_SETUP);
        if (n == 1000) begin
            miscompares++;
            test_done();
        end
        `CHK(q[2], 1'b1)
        `CHK(chip_reset_req, 1'b0)
        wr(OFS_SETUP, 32'h1);
        rd(OFS_SETUP);
        `CHK(q, 32'h1)
    endtask
    task automatic t_feed_error;
        wr(OFS_SETUP, 32'h3);
        wr(OFS_FEED, 32'haa);
        rd(OFS_SETUP);
        repeat (3) @(posedge clock);
        `CHK(chip_reset_req, 1'b0)
        rd(OFS_SETUP);
        `CHK(q[2], 1'b1)
        wr(OFS_SETUP, 32'h3);
        feed();
        wr(OFS_FEED, 32'haa);
        wr(OFS_RELOAD, 32'h200);
        @(posedge clock);
        #1;
        `CHK(chip_reset_req, 1'b1)
        pulse_sys();
        rd(OFS_SETUP);
        `CHK(q, 32'h4)
        `CHK(chip_reset_req, 1'b0)
        @(posedge clock);
        #1 rstn = 0;
        @(posedge clock);
        #1 rstn = 1;
        rd(OFS_SETUP);
        `CHK(q, 32'h0)
    endtask
    task automatic t_window;
        int n;
        wr(OFS_RELOAD, 32'h300);
        wr(OFS_WINDOW, 32'h200);
        wr(OFS_WARN, 32'h280);
        wr(OFS_SETUP, 32'h13);
        feed();
        feed();
        rd(OFS_SETUP);
        `CHK(q[2], 1'b1)
        `CHK(chip_reset_req, 1'b1)
        wr(OFS_SETUP, 32'h13);
        wr(OFS_RELOAD, 32'h400);
        rd(OFS_SETUP);
        `CHK(q, 32'h17)
        rd(OFS_RELOAD);
        `CHK(q, 32'h300)
        for (n = 0; n < 1000 && q[23:0] >= 24'h1f0; n++) rd(OFS_COUNT);
        if (n == 1000) begin
            miscompares++;
            test_done();
        end
        wr(OFS_RELOAD, 32'h500);
        rd(OFS_RELOAD);
        `CHK(q, 32'h500)
    endtask
    initial begin
        repeat (12) @(posedge clock);
        #1 rstn = 1;
        t_reset_values();
        t_reload();
        t_lock();
        t_run();
        t_feed_error();
        t_window();
        test_done();
    end
endmodule
bind wwd_regs wwd_regs_chk wwd_regs_chk_inst (.clock(clock), .rstn(rstn),
    .sys_reset(sys_reset), .tick_enable(tick_enable), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .source_ready(source_ready), .chip_reset_req(chip_reset_req),
    .warning_irq(warning_irq), .source_select(source_select), .source_hold(source_hold));

// [tb/wwd_cpu_model.sv]
module wwd_cpu_model
    import wwd_pkg::*;
(
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic tick_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        tick_enable = 0;
    end
    always @(posedge clock) begin
        tick_enable <= #1 ~tick_enable;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clock);
        #1;
        psel = 1;
        pwrite = w;
        paddr = a;
        pwdata = (a == OFS_SETUP) ? (d & 32'h0000003f) : d;
        @(posedge clock);
        #1;
        penable = 1;
        @(posedge clock);
        q = prdata;
        e = pslverr;
        #1;
        psel = 0;
        penable = 0;
    endtask
endmodule

// [tb/wwd_regs_chk.sv]
module wwd_regs_chk
    import wwd_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic sys_reset,
    input wire logic tick_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] source_ready,
    input wire logic chip_reset_req,
    input wire logic warning_irq,
    input wire logic source_select,
    input wire logic [1:0] source_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire logic acc = psel && penable;
    wire logic setup_wr = acc && pwrite && paddr == OFS_SETUP;
    wire logic clr_tof = setup_wr && !pwdata[BIT_TIMEOUT];
    wire logic clr_warn = setup_wr && !pwdata[BIT_WARNING];
    a_unmapped_err: assert property (acc && paddr > OFS_WINDOW |-> pslverr && pready)
        else $error("unmapped access not flagged");
    a_slverr_idle: assert property (!acc |-> !pslverr)
        else $error("error response outside access");
    a_feed_reads_zero: assert property (
        acc && !pwrite && paddr == OFS_FEED |-> prdata == 0)
        else $error("feed register read not zero");
    a_hold_select: assert property (
        source_hold != 2'h0 |-> source_hold == {source_select, !source_select})
        else $error("held source differs from selected");
    a_lock_sticky: assert property (
        source_hold != 2'h0 && !sys_reset |=> source_hold != 2'h0)
        else $error("clock lock dropped");
    a_switch_refused: assert property (
        acc && pwrite && paddr == OFS_SOURCE && source_hold != 2'h0
        && !source_ready[pwdata[0]] && !sys_reset |=> $stable(source_select))
        else $error("switched to a source that is not ready");
    a_sysreset_clears: assert property (
        sys_reset |=> !warning_irq && source_hold == 2'h0
        && !source_select ##1 !chip_reset_req)
        else $error("system reset left state behind");
    a_warn_holds: assert property (
        warning_irq && !sys_reset && !clr_warn |=> warning_irq)
        else $error("warning flag lost");
    a_reset_req_holds: assert property (
        chip_reset_req && !sys_reset && !$past(sys_reset)
        && !clr_tof && !$past(clr_tof) |=> chip_reset_req)
        else $error("reset request dropped");
    c_reset_req: cover property (chip_reset_req);
    c_warning: cover property (warning_irq);
    c_locked: cover property (source_hold != 2'h0);
    c_slverr: cover property (acc && pslverr);
endmodule
